// [verilog/tpmr_regs.svh]
`ifndef TPMR_REGS_SVH
`define TPMR_REGS_SVH

// Read command codes
`define TPMR_CMD_READ_VIN 8'h88
`define TPMR_CMD_READ_IIN 8'h89
`define TPMR_CMD_READ_PIN 8'h97
`define TPMR_CMD_READ_VOUT 8'h8b
`define TPMR_CMD_READ_IOUT 8'h8c
`define TPMR_CMD_READ_TEMP1 8'h8d
`define TPMR_CMD_READ_TEMP2 8'h8e
`define TPMR_CMD_READ_POUT 8'h96
`define TPMR_CMD_IOUT_FINE 8'hbb
`define TPMR_CMD_IIN_HIGH 8'hc4
`define TPMR_CMD_IIN_LOW 8'hc5
`define TPMR_CMD_PIN_HIGH 8'hc6
`define TPMR_CMD_PIN_LOW 8'hc7
`define TPMR_CMD_SENSE_RAW 8'hfa
`define TPMR_CMD_VIN_HIGH 8'hde
`define TPMR_CMD_VOUT_HIGH 8'hdd
`define TPMR_CMD_IOUT_HIGH 8'hd7
`define TPMR_CMD_TEMP1_HIGH 8'hdf
`define TPMR_CMD_VIN_LOW 8'hfc
`define TPMR_CMD_VOUT_LOW 8'hfb
`define TPMR_CMD_IOUT_LOW 8'hd8
`define TPMR_CMD_TEMP1_LOW 8'hfd

// Tracker reset values
`define TPMR_L11_HIGH_RST 16'h7c00
`define TPMR_L11_LOW_RST 16'h7bff
`define TPMR_L16_HIGH_RST 16'hf800
`define TPMR_L16_LOW_RST 16'hffff

// Reading reset value, fine format limits and scale
`define TPMR_READING_RST 16'h0000
`define TPMR_FINE_POS_SAT 16'h7fff
`define TPMR_FINE_NEG_SAT 16'h8000
`define TPMR_FINE_PER_AMP 58'sd400
`define TPMR_FIX_FRAC 16

`endif

// [verilog/tpmr_pkg.sv]
`default_nettype none

package tpmr_pkg;

  // Kind of a finished conversion, one-hot
  typedef enum logic [7:0] {
    TPMR_K_VIN   = 8'h01,
    TPMR_K_IIN   = 8'h02,
    TPMR_K_VOUT  = 8'h04,
    TPMR_K_IOUT  = 8'h08,
    TPMR_K_TEXT  = 8'h10,
    TPMR_K_TDIE  = 8'h20,
    TPMR_K_POUT  = 8'h40,
    TPMR_K_SENSE = 8'h80
  } tpmr_kind_t;

  typedef struct packed {
    logic [15:0] mark;
  } tpmr_mark_t;

  typedef struct packed {
    logic [15:0] vin;
    logic [15:0] iin;
    logic [15:0] pin;
    logic [15:0] tdie;
    logic [3:0][15:0] vout;
    logic [3:0][15:0] iout;
    logic [3:0][15:0] pout;
    logic [3:0][15:0] t_ext;
    logic [3:0][15:0] fine;
    logic [3:0][15:0] sense;
    logic [3:0] t_bad;
    logic [3:0] on_prev;
    logic [15:0] rd_data;
    logic rd_valid;
    logic rd_err;
  } tpmr_state_t;

  // L11 word to signed fixed point with 16 fraction bits
  function automatic logic signed [47:0] tpmr_l11_fix(input logic [15:0] w);
    logic signed [47:0] m;
    logic [5:0] sh;
    m = $signed({{37{w[10]}}, w[10:0]});
    sh = {w[15], w[15:11]} + 6'h10;
    return m <<< sh;
  endfunction

endpackage

`default_nettype wire

// [verilog/tpmr_tracker.sv]
`timescale 1ns/10ps
`default_nettype none
`include "tpmr_regs.svh"

module tpmr_tracker
  import tpmr_pkg::*;
#(
  parameter logic [15:0] RESET_VAL = 16'h7c00,
  parameter bit IS_MAX = 1'b1,
  parameter bit IS_L11 = 1'b1
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic clr_i,
  input wire logic upd_i,
  input wire logic [15:0] val_i,
  output logic [15:0] mark_o
);

  tpmr_mark_t st_r;
  tpmr_mark_t st_nxt;
  logic better;

  // Compare in the value's own format, not as raw bits
  always_comb begin
    if (IS_L11) begin
      better = IS_MAX ? (tpmr_l11_fix(val_i) > tpmr_l11_fix(st_r.mark))
                      : (tpmr_l11_fix(val_i) < tpmr_l11_fix(st_r.mark));
    end else begin
      // The L16 peak start word means zero, so the first reading replaces it
      better = IS_MAX ? (val_i > st_r.mark || st_r.mark == RESET_VAL)
                      : (val_i < st_r.mark);
    end
    st_nxt = st_r;
    if (clr_i) begin
      st_nxt.mark = RESET_VAL;
    end else if (upd_i && better) begin
      st_nxt.mark = val_i;
    end
  end

  // Power-on reset loads the documented start value
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_r.mark <= RESET_VAL;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign mark_o = st_r.mark;

  chk_tracker_clear_wins: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    clr_i |=> mark_o == RESET_VAL)
    else $error("tracker not reset after clear");

  chk_tracker_takes_better: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    (upd_i && !clr_i && better) |=> (mark_o == $past(val_i)))
    else $error("tracker missed a better value");

endmodule

`default_nettype wire

// [verilog/tpmr_top.sv]
// How it works
// - Output voltage read returns latest page conversion
// - Output current read returns latest page conversion
// - Input current peak, reset 0x7C00 on events
// - Input current minimum, reset 0x7BFF on events
// - Input power peak, reset 0x7C00 on events
// - Input power minimum, reset 0x7BFF on events
// - Paged temperature one is the used value
// - Invalid external sense reports die temperature
// - Stuck pin or high ideality means invalid
// - Unpaged die temperature read affects nothing else
// - Output power read returns latest page value
// - Fine current is signed, 2.5 mA steps
// - Fine current saturates at 81.92 A
// - Sense voltage is unsigned 16-bit magnitude
// - Sense voltage is absolute raw, uncorrected
// - Input voltage peak, reset 0x7C00 on events
// - Output voltage peak per page, reset 0xF800
// - Output current peak per page, reset 0x7C00
// - Temperature peak per page, reset 0x7C00
// - Input voltage minimum, reset 0x7BFF on events
// - Input power equals input current times voltage
`timescale 1ns/10ps
`default_nettype none
`include "tpmr_regs.svh"

module tpmr_top
  import tpmr_pkg::*;
#(
  parameter logic [7:0] DIODE_IDEALITY_LIMIT = 8'h80
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic conv_valid_i,
  input wire tpmr_kind_t conv_kind_i,
  input wire logic [1:0] conv_page_i,
  input wire logic [15:0] conv_data_i,
  input wire logic [7:0] conv_ideality_i,
  input wire logic [3:0] ext_sense_stuck_i,
  input wire logic [3:0] chan_on_i,
  input wire logic clear_faults_i,
  input wire logic [1:0] clear_page_i,
  input wire logic rd_req_i,
  input wire logic [7:0] rd_cmd_i,
  input wire logic [1:0] rd_page_i,
  output logic [15:0] rd_data_o,
  output logic rd_valid_o,
  output logic rd_err_o
);

  logic [1:0] rst_q;
  logic rst_b;
  tpmr_state_t st_r;
  tpmr_state_t st_nxt;
  logic [3:0] rise;
  logic glob_clr;
  logic vin_upd;
  logic iin_upd;
  logic pin_upd;
  logic [3:0] vout_upd;
  logic [3:0] iout_upd;
  logic [3:0] t1_upd;
  logic [3:0] ch_clr;
  logic [3:0][15:0] t1_val;
  logic [15:0] vin_hi, vin_lo, iin_hi, iin_lo, pin_hi, pin_lo;
  logic [3:0][15:0] vout_hi, vout_lo, iout_hi, iout_lo, t1_hi, t1_lo;

  // Reset released through two flops, asserted at once
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rst_q <= 2'h0;
    end else begin
      rst_q <= {rst_q[0], 1'b1};
    end
  end
  assign rst_b = rst_q[1];

  // L11 product, renormalised to an 11-bit mantissa
  function automatic logic [15:0] pin_mul(input logic [15:0] a,
                                          input logic [15:0] b);
    logic signed [21:0] m;
    logic signed [6:0] e;
    integer k;
    m = $signed(a[10:0]) * $signed(b[10:0]);
    e = $signed({{2{a[15]}}, a[15:11]}) + $signed({{2{b[15]}}, b[15:11]});
    for (k = 0; k < 17; k++) begin
      if (m > 22'sd1023 || m < -22'sd1024 || e < -7'sd16) begin
        m = m >>> 1;
        e = e + 7'sd1;
      end
    end
    // Exponent overflow clips to the largest magnitude
    if (e > 7'sd15) begin
      return m[21] ? 16'h7c00 : 16'h7bff;
    end
    return {e[4:0], m[10:0]};
  endfunction

  // L11 current to signed 2.5 mA counts, clipped to 16 bits
  function automatic logic [15:0] fine_fmt(input logic [15:0] w);
    logic signed [57:0] p;
    logic signed [57:0] q;
    p = $signed({{10{w[10]}}, tpmr_l11_fix(w)}) * `TPMR_FINE_PER_AMP;
    q = p >>> `TPMR_FIX_FRAC;
    if (q > 58'sd32767) begin
      return `TPMR_FINE_POS_SAT;
    end else if (q < -58'sd32768) begin
      return `TPMR_FINE_NEG_SAT;
    end
    return q[15:0];
  endfunction

  // Reset events: any clear or any turn-on hits shared trackers
  assign rise = chan_on_i & ~st_r.on_prev;
  assign glob_clr = clear_faults_i || (|rise);
  assign vin_upd = conv_valid_i && conv_kind_i == TPMR_K_VIN;
  assign iin_upd = conv_valid_i && conv_kind_i == TPMR_K_IIN;
  assign pin_upd = vin_upd || iin_upd;

  // Conversion capture and read answer
  always_comb begin
    st_nxt = st_r;
    st_nxt.on_prev = chan_on_i;
    st_nxt.rd_valid = 1'b0;
    st_nxt.rd_err = 1'b0;
    if (conv_valid_i) begin
      case (conv_kind_i)
        TPMR_K_VIN: begin
          st_nxt.vin = conv_data_i;
          st_nxt.pin = pin_mul(conv_data_i, st_r.iin);
        end
        TPMR_K_IIN: begin
          st_nxt.iin = conv_data_i;
          st_nxt.pin = pin_mul(st_r.vin, conv_data_i);
        end
        TPMR_K_VOUT: begin
          st_nxt.vout[conv_page_i] = conv_data_i;
        end
        TPMR_K_IOUT: begin
          st_nxt.iout[conv_page_i] = conv_data_i;
          st_nxt.fine[conv_page_i] = fine_fmt(conv_data_i);
        end
        TPMR_K_TEXT: begin
          st_nxt.t_ext[conv_page_i] = conv_data_i;
          st_nxt.t_bad[conv_page_i] = ext_sense_stuck_i[conv_page_i] ||
            (conv_ideality_i > DIODE_IDEALITY_LIMIT);
        end
        TPMR_K_TDIE: begin
          st_nxt.tdie = conv_data_i;
        end
        TPMR_K_POUT: begin
          st_nxt.pout[conv_page_i] = conv_data_i;
        end
        TPMR_K_SENSE: begin
          // Raw signed difference folded to magnitude, uncorrected
          st_nxt.sense[conv_page_i] = conv_data_i[15] ?
            (~conv_data_i) + 16'h0001 : conv_data_i;
        end
        default: begin
        end
      endcase
    end
    // Reads see the state before this cycle's capture
    if (rd_req_i) begin
      st_nxt.rd_valid = 1'b1;
      st_nxt.rd_data = `TPMR_READING_RST;
      if (rd_cmd_i == `TPMR_CMD_READ_VIN) begin
        st_nxt.rd_data = st_r.vin;
      end else if (rd_cmd_i == `TPMR_CMD_READ_IIN) begin
        st_nxt.rd_data = st_r.iin;
      end else if (rd_cmd_i == `TPMR_CMD_READ_PIN) begin
        st_nxt.rd_data = st_r.pin;
      end else if (rd_cmd_i == `TPMR_CMD_READ_VOUT) begin
        st_nxt.rd_data = st_r.vout[rd_page_i];
      end else if (rd_cmd_i == `TPMR_CMD_READ_IOUT) begin
        st_nxt.rd_data = st_r.iout[rd_page_i];
      end else if (rd_cmd_i == `TPMR_CMD_READ_TEMP1) begin
        st_nxt.rd_data = st_r.t_bad[rd_page_i] ? st_r.tdie
                       : st_r.t_ext[rd_page_i];
      end else if (rd_cmd_i == `TPMR_CMD_READ_TEMP2) begin
        st_nxt.rd_data = st_r.tdie;
      end else if (rd_cmd_i == `TPMR_CMD_READ_POUT) begin
        st_nxt.rd_data = st_r.pout[rd_page_i];
      end else if (rd_cmd_i == `TPMR_CMD_IOUT_FINE) begin
        st_nxt.rd_data = st_r.fine[rd_page_i];
      end else if (rd_cmd_i == `TPMR_CMD_SENSE_RAW) begin
        st_nxt.rd_data = st_r.sense[rd_page_i];
      end else if (rd_cmd_i == `TPMR_CMD_IIN_HIGH) begin
        st_nxt.rd_data = iin_hi;
      end else if (rd_cmd_i == `TPMR_CMD_IIN_LOW) begin
        st_nxt.rd_data = iin_lo;
      end else if (rd_cmd_i == `TPMR_CMD_PIN_HIGH) begin
        st_nxt.rd_data = pin_hi;
      end else if (rd_cmd_i == `TPMR_CMD_PIN_LOW) begin
        st_nxt.rd_data = pin_lo;
      end else if (rd_cmd_i == `TPMR_CMD_VIN_HIGH) begin
        st_nxt.rd_data = vin_hi;
      end else if (rd_cmd_i == `TPMR_CMD_VIN_LOW) begin
        st_nxt.rd_data = vin_lo;
      end else if (rd_cmd_i == `TPMR_CMD_VOUT_HIGH) begin
        st_nxt.rd_data = vout_hi[rd_page_i];
      end else if (rd_cmd_i == `TPMR_CMD_VOUT_LOW) begin
        st_nxt.rd_data = vout_lo[rd_page_i];
      end else if (rd_cmd_i == `TPMR_CMD_IOUT_HIGH) begin
        st_nxt.rd_data = iout_hi[rd_page_i];
      end else if (rd_cmd_i == `TPMR_CMD_IOUT_LOW) begin
        st_nxt.rd_data = iout_lo[rd_page_i];
      end else if (rd_cmd_i == `TPMR_CMD_TEMP1_HIGH) begin
        st_nxt.rd_data = t1_hi[rd_page_i];
      end else if (rd_cmd_i == `TPMR_CMD_TEMP1_LOW) begin
        st_nxt.rd_data = t1_lo[rd_page_i];
      end else begin
        st_nxt.rd_err = 1'b1; // Unknown code answers zero with error
      end
    end
  end

  // Readings start at zero; nothing is measured yet
  always_ff @(posedge clk_i or negedge rst_b) begin
    if (!rst_b) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rd_data_o = st_r.rd_data;
  assign rd_valid_o = st_r.rd_valid;
  assign rd_err_o = st_r.rd_err;

  // Shared trackers, reset by any clear or any turn-on
  tpmr_tracker #(.RESET_VAL(`TPMR_L11_HIGH_RST), .IS_MAX(1'b1), .IS_L11(1'b1))
    u_vin_hi (.clk_i(clk_i), .rst_b_i(rst_b), .clr_i(glob_clr),
              .upd_i(vin_upd), .val_i(conv_data_i), .mark_o(vin_hi));
  tpmr_tracker #(.RESET_VAL(`TPMR_L11_LOW_RST), .IS_MAX(1'b0), .IS_L11(1'b1))
    u_vin_lo (.clk_i(clk_i), .rst_b_i(rst_b), .clr_i(glob_clr),
              .upd_i(vin_upd), .val_i(conv_data_i), .mark_o(vin_lo));
  tpmr_tracker #(.RESET_VAL(`TPMR_L11_HIGH_RST), .IS_MAX(1'b1), .IS_L11(1'b1))
    u_iin_hi (.clk_i(clk_i), .rst_b_i(rst_b), .clr_i(glob_clr),
              .upd_i(iin_upd), .val_i(conv_data_i), .mark_o(iin_hi));
  tpmr_tracker #(.RESET_VAL(`TPMR_L11_LOW_RST), .IS_MAX(1'b0), .IS_L11(1'b1))
    u_iin_lo (.clk_i(clk_i), .rst_b_i(rst_b), .clr_i(glob_clr),
              .upd_i(iin_upd), .val_i(conv_data_i), .mark_o(iin_lo));
  tpmr_tracker #(.RESET_VAL(`TPMR_L11_HIGH_RST), .IS_MAX(1'b1), .IS_L11(1'b1))
    u_pin_hi (.clk_i(clk_i), .rst_b_i(rst_b), .clr_i(glob_clr),
              .upd_i(pin_upd), .val_i(st_nxt.pin), .mark_o(pin_hi));
  tpmr_tracker #(.RESET_VAL(`TPMR_L11_LOW_RST), .IS_MAX(1'b0), .IS_L11(1'b1))
    u_pin_lo (.clk_i(clk_i), .rst_b_i(rst_b), .clr_i(glob_clr),
              .upd_i(pin_upd), .val_i(st_nxt.pin), .mark_o(pin_lo));

  // Per-page trackers, reset by own-page clear or own turn-on
  for (genvar c = 0; c < 4; c++) begin : g_ch
    assign ch_clr[c] = (clear_faults_i && clear_page_i == 2'(c)) || rise[c];
    assign vout_upd[c] = conv_valid_i && conv_kind_i == TPMR_K_VOUT &&
                         conv_page_i == 2'(c);
    assign iout_upd[c] = conv_valid_i && conv_kind_i == TPMR_K_IOUT &&
                         conv_page_i == 2'(c);
    // A die reading also feeds a page whose diode is invalid
    assign t1_upd[c] = conv_valid_i &&
      ((conv_kind_i == TPMR_K_TEXT && conv_page_i == 2'(c)) ||
       (conv_kind_i == TPMR_K_TDIE && st_r.t_bad[c]));
    assign t1_val[c] = (conv_kind_i == TPMR_K_TEXT &&
      (ext_sense_stuck_i[c] || conv_ideality_i > DIODE_IDEALITY_LIMIT))
      ? st_r.tdie : conv_data_i;
    tpmr_tracker #(.RESET_VAL(`TPMR_L16_HIGH_RST), .IS_MAX(1'b1),
                   .IS_L11(1'b0))
      u_vout_hi (.clk_i(clk_i), .rst_b_i(rst_b), .clr_i(ch_clr[c]),
                 .upd_i(vout_upd[c]), .val_i(conv_data_i),
                 .mark_o(vout_hi[c]));
    tpmr_tracker #(.RESET_VAL(`TPMR_L16_LOW_RST), .IS_MAX(1'b0),
                   .IS_L11(1'b0))
      u_vout_lo (.clk_i(clk_i), .rst_b_i(rst_b), .clr_i(ch_clr[c]),
                 .upd_i(vout_upd[c]), .val_i(conv_data_i),
                 .mark_o(vout_lo[c]));
    tpmr_tracker #(.RESET_VAL(`TPMR_L11_HIGH_RST), .IS_MAX(1'b1),
                   .IS_L11(1'b1))
      u_iout_hi (.clk_i(clk_i), .rst_b_i(rst_b), .clr_i(ch_clr[c]),
                 .upd_i(iout_upd[c]), .val_i(conv_data_i),
                 .mark_o(iout_hi[c]));
    tpmr_tracker #(.RESET_VAL(`TPMR_L11_LOW_RST), .IS_MAX(1'b0),
                   .IS_L11(1'b1))
      u_iout_lo (.clk_i(clk_i), .rst_b_i(rst_b), .clr_i(ch_clr[c]),
                 .upd_i(iout_upd[c]), .val_i(conv_data_i),
                 .mark_o(iout_lo[c]));
    tpmr_tracker #(.RESET_VAL(`TPMR_L11_HIGH_RST), .IS_MAX(1'b1),
                   .IS_L11(1'b1))
      u_t1_hi (.clk_i(clk_i), .rst_b_i(rst_b), .clr_i(ch_clr[c]),
               .upd_i(t1_upd[c]), .val_i(t1_val[c]),
               .mark_o(t1_hi[c]));
    tpmr_tracker #(.RESET_VAL(`TPMR_L11_LOW_RST), .IS_MAX(1'b0),
                   .IS_L11(1'b1))
      u_t1_lo (.clk_i(clk_i), .rst_b_i(rst_b), .clr_i(ch_clr[c]),
               .upd_i(t1_upd[c]), .val_i(t1_val[c]),
               .mark_o(t1_lo[c]));
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b);

  chk_vout_latest: assert property (
    conv_valid_i && conv_kind_i == TPMR_K_VOUT && conv_page_i == 2'h0
    |=> st_r.vout[0] == $past(conv_data_i))
    else $error("vout not captured");
  chk_iout_latest: assert property (
    conv_valid_i && conv_kind_i == TPMR_K_IOUT && conv_page_i == 2'h1
    |=> st_r.iout[1] == $past(conv_data_i))
    else $error("iout not captured");
  chk_iin_peak_clear: assert property (
    clear_faults_i |=> iin_hi == `TPMR_L11_HIGH_RST)
    else $error("iin peak not reset");
  chk_iin_min_turnon: assert property (
    chan_on_i[3] && !st_r.on_prev[3] |=> iin_lo == `TPMR_L11_LOW_RST)
    else $error("iin min not reset on turn-on");
  chk_pin_peak_clear: assert property (
    clear_faults_i |=> pin_hi == `TPMR_L11_HIGH_RST)
    else $error("pin peak not reset");
  chk_pin_min_turnon: assert property (
    chan_on_i[3] && !st_r.on_prev[3] |=> pin_lo == `TPMR_L11_LOW_RST)
    else $error("pin min not reset on turn-on");
  chk_temp_substitute: assert property (
    rd_req_i && rd_cmd_i == `TPMR_CMD_READ_TEMP1 && rd_page_i == 2'h0 &&
    st_r.t_bad[0] |=> rd_valid_o && rd_data_o == $past(st_r.tdie))
    else $error("die temperature not substituted");
  chk_ideality_bad: assert property (
    conv_valid_i && conv_kind_i == TPMR_K_TEXT && conv_page_i == 2'h0 &&
    conv_ideality_i > DIODE_IDEALITY_LIMIT |=> st_r.t_bad[0])
    else $error("high ideality not flagged");
  chk_die_read: assert property (
    rd_req_i && rd_cmd_i == `TPMR_CMD_READ_TEMP2
    |=> rd_valid_o && !rd_err_o && rd_data_o == $past(st_r.tdie))
    else $error("die temperature read wrong");
  chk_fine_scale: assert property (
    conv_valid_i && conv_kind_i == TPMR_K_IOUT && conv_page_i == 2'h2 &&
    conv_data_i == 16'h0002 |=> st_r.fine[2] == 16'h0320)
    else $error("fine current scale wrong");
  chk_fine_sat: assert property (
    conv_valid_i && conv_kind_i == TPMR_K_IOUT && conv_page_i == 2'h2 &&
    conv_data_i == 16'h0832 |=> st_r.fine[2] == `TPMR_FINE_POS_SAT)
    else $error("fine current not saturated");
  chk_sense_abs: assert property (
    conv_valid_i && conv_kind_i == TPMR_K_SENSE && conv_page_i == 2'h1 &&
    conv_data_i[15] |=> st_r.sense[1] == (~$past(conv_data_i)) + 16'h0001)
    else $error("sense magnitude wrong");
  chk_vout_peak_page: assert property (
    clear_faults_i && clear_page_i == 2'h2 && !rise[0] && !vout_upd[0]
    |=> vout_hi[2] == `TPMR_L16_HIGH_RST && $stable(vout_hi[0]))
    else $error("vout peak not reset by page clear");
  chk_pin_product: assert property (
    vin_upd |=> st_r.pin == pin_mul($past(conv_data_i), $past(st_r.iin)))
    else $error("input power not product");

endmodule

`default_nettype wire

// [bench/tpmr_host_model.sv]
`timescale 1ns/10ps
`default_nettype none

module tpmr_host_model (
  input wire logic clk_i,
  input wire logic rd_valid_i,
  input wire logic rd_err_i,
  input wire logic [15:0] rd_data_i,
  output logic rd_req_o,
  output logic [7:0] rd_cmd_o,
  output logic [1:0] rd_page_o
);
  initial begin
    rd_req_o = 1'b0;
    rd_cmd_o = 8'h00;
    rd_page_o = 2'h0;
  end

  // One word read; answer sampled mid-cycle, bounded wait
  task automatic read(input logic [7:0] c, input logic [1:0] p,
                      output logic [16:0] r);
    int n;
    @(posedge clk_i);
    rd_req_o <= 1'b1;
    rd_cmd_o <= c;
    rd_page_o <= p;
    @(posedge clk_i);
    rd_req_o <= 1'b0;
    rd_cmd_o <= ~c; // Released lines never keep the old code
    rd_page_o <= ~p;
    n = 0;
    do begin
      @(negedge clk_i);
      n++;
    end while (rd_valid_i !== 1'b1 && n < 4);
    r = (rd_valid_i === 1'b1) ? {rd_err_i, rd_data_i} : 'x;
  endtask
endmodule
`default_nettype wire

// [bench/tpmr_top_tb.sv]
`timescale 1ns/10ps
`default_nettype none
`include "tpmr_regs.svh"

module tpmr_top_tb
  import tpmr_pkg::*;
;
  logic clk_i = 1'b0;
  logic rst_b = 1'b0;
  logic cv = 1'b0;
  tpmr_kind_t ck = TPMR_K_VIN;
  logic [1:0] cp = 2'h0;
  logic [15:0] cd = 16'h0000;
  logic [7:0] cn = 8'h00;
  logic [3:0] stuck = 4'h0;
  logic [3:0] on = 4'h0;
  logic [3:0] on_next = 4'h0;
  logic clr_f = 1'b0;
  logic [1:0] clr_p = 2'h0;
  logic rq, vl, er;
  logic [7:0] rc;
  logic [1:0] rp;
  logic [15:0] rdat;
  int n_mismatch = 0;
  int total_checks = 0;

  always #50 clk_i = ~clk_i;

  tpmr_top i_tpmr_top (.clk_i(clk_i), .rst_b_i(rst_b), .conv_valid_i(cv),
    .conv_kind_i(ck), .conv_page_i(cp), .conv_data_i(cd),
    .conv_ideality_i(cn), .ext_sense_stuck_i(stuck), .chan_on_i(on),
    .clear_faults_i(clr_f), .clear_page_i(clr_p), .rd_req_i(rq),
    .rd_cmd_i(rc), .rd_page_i(rp), .rd_data_o(rdat), .rd_valid_o(vl),
    .rd_err_o(er));

  tpmr_host_model i_tpmr_host_model (.clk_i(clk_i), .rd_valid_i(vl),
    .rd_err_i(er), .rd_data_i(rdat), .rd_req_o(rq), .rd_cmd_o(rc),
    .rd_page_o(rp));

  // Read one word and compare error flag plus data
  task automatic rd(input logic [7:0] c, input logic [1:0] p,
                    input logic [15:0] x);
    logic [16:0] r;
    i_tpmr_host_model.read(c, p, r);
    total_checks++;
    if (r !== {1'b0, x}) begin
      n_mismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, r, {1'b0, x});
    end
  endtask

  // One conversion pulse; channel on state moves with it
  task automatic conv(input tpmr_kind_t k, input logic [1:0] p,
                      input logic [15:0] d, input logic [7:0] n);
    @(posedge clk_i);
    cv <= 1'b1;
    ck <= k;
    cp <= p;
    cd <= d;
    cn <= n;
    on <= on_next;
    @(posedge clk_i);
    cv <= 1'b0;
    cd <= ~d;
  endtask

  task automatic clr(input logic [1:0] p);
    @(posedge clk_i);
    clr_f <= 1'b1;
    clr_p <= p;
    @(posedge clk_i);
    clr_f <= 1'b0;
  endtask

  task automatic t_reset;
    logic [16:0] r;
    rd(`TPMR_CMD_IIN_HIGH, 2'h0, 16'h7c00);
    rd(`TPMR_CMD_IIN_LOW, 2'h0, 16'h7bff);
    rd(`TPMR_CMD_PIN_HIGH, 2'h0, 16'h7c00);
    rd(`TPMR_CMD_PIN_LOW, 2'h0, 16'h7bff);
    rd(`TPMR_CMD_VIN_HIGH, 2'h0, 16'h7c00);
    rd(`TPMR_CMD_VIN_LOW, 2'h0, 16'h7bff);
    rd(`TPMR_CMD_VOUT_HIGH, 2'h3, 16'hf800);
    rd(`TPMR_CMD_IOUT_HIGH, 2'h1, 16'h7c00);
    rd(`TPMR_CMD_TEMP1_HIGH, 2'h2, 16'h7c00);
    // Unknown code answers a zero word with the error flag
    i_tpmr_host_model.read(8'h00, 2'h0, r);
    total_checks++;
    if (r !== 17'h10000) begin
      n_mismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, r, 17'h10000);
    end
  endtask

  task automatic t_read;
    conv(TPMR_K_VOUT, 2'h1, 16'h1234, 8'h00);
    rd(`TPMR_CMD_READ_VOUT, 2'h1, 16'h1234);
    rd(`TPMR_CMD_READ_VOUT, 2'h0, 16'h0000);
    conv(TPMR_K_IOUT, 2'h2, 16'h0002, 8'h00);
    rd(`TPMR_CMD_READ_IOUT, 2'h2, 16'h0002);
    conv(TPMR_K_POUT, 2'h3, 16'h0005, 8'h00);
    rd(`TPMR_CMD_READ_POUT, 2'h3, 16'h0005);
  endtask

  // Numeric order differs from raw word order for the input voltage and power values
  task automatic t_track;
    conv(TPMR_K_VIN, 2'h0, 16'h0005, 8'h00);
    conv(TPMR_K_VIN, 2'h0, 16'h0801, 8'h00);
    conv(TPMR_K_VIN, 2'h0, 16'h07ff, 8'h00);
    conv(TPMR_K_IIN, 2'h0, 16'h0006, 8'h00);
    conv(TPMR_K_IIN, 2'h0, 16'h0002, 8'h00);
    rd(`TPMR_CMD_VIN_HIGH, 2'h0, 16'h0005);
    rd(`TPMR_CMD_VIN_LOW, 2'h0, 16'h07ff);
    rd(`TPMR_CMD_IIN_HIGH, 2'h0, 16'h0006);
    rd(`TPMR_CMD_IIN_LOW, 2'h0, 16'h0002);
    rd(`TPMR_CMD_READ_PIN, 2'h0, 16'h07fe);
    rd(`TPMR_CMD_PIN_HIGH, 2'h0, 16'h0000);
    rd(`TPMR_CMD_PIN_LOW, 2'h0, 16'h07fa);
    conv(TPMR_K_VOUT, 2'h0, 16'h2000, 8'h00);
    conv(TPMR_K_VOUT, 2'h2, 16'h3000, 8'h00);
    clr(2'h2);
    rd(`TPMR_CMD_VIN_HIGH, 2'h0, 16'h7c00);
    rd(`TPMR_CMD_IIN_LOW, 2'h0, 16'h7bff);
    rd(`TPMR_CMD_PIN_HIGH, 2'h0, 16'h7c00);
    rd(`TPMR_CMD_PIN_LOW, 2'h0, 16'h7bff);
    rd(`TPMR_CMD_VOUT_HIGH, 2'h0, 16'h2000);
    rd(`TPMR_CMD_VOUT_LOW, 2'h0, 16'h2000);
    rd(`TPMR_CMD_VOUT_HIGH, 2'h2, 16'hf800);
    rd(`TPMR_CMD_IOUT_HIGH, 2'h2, 16'h7c00);
  endtask

  // Turn-on in the same cycle as a conversion: reset must win
  task automatic t_on;
    conv(TPMR_K_VOUT, 2'h3, 16'h4000, 8'h00);
    on_next = 4'h8;
    conv(TPMR_K_VIN, 2'h0, 16'h0009, 8'h00);
    rd(`TPMR_CMD_VIN_HIGH, 2'h0, 16'h7c00);
    rd(`TPMR_CMD_VOUT_HIGH, 2'h3, 16'hf800);
    rd(`TPMR_CMD_VOUT_HIGH, 2'h0, 16'h2000);
  endtask

  task automatic t_temp;
    conv(TPMR_K_TDIE, 2'h0, 16'h0019, 8'h00);
    conv(TPMR_K_TEXT, 2'h0, 16'h0028, 8'h81);
    rd(`TPMR_CMD_READ_TEMP1, 2'h0, 16'h0019);
    rd(`TPMR_CMD_READ_TEMP2, 2'h0, 16'h0019);
    conv(TPMR_K_TEXT, 2'h1, 16'h0028, 8'h80);
    rd(`TPMR_CMD_READ_TEMP1, 2'h1, 16'h0028);
    rd(`TPMR_CMD_TEMP1_HIGH, 2'h1, 16'h0028);
    rd(`TPMR_CMD_TEMP1_LOW, 2'h1, 16'h0028);
    rd(`TPMR_CMD_TEMP1_HIGH, 2'h0, 16'h0019);
    @(posedge clk_i);
    stuck <= 4'h4;
    conv(TPMR_K_TEXT, 2'h2, 16'h0028, 8'h00);
    rd(`TPMR_CMD_READ_TEMP1, 2'h2, 16'h0019);
  endtask

  // 1 A, -1 A, +100 A and -100 A in the fine format
  task automatic t_fine;
    conv(TPMR_K_IOUT, 2'h0, 16'h0001, 8'h00);
    conv(TPMR_K_IOUT, 2'h1, 16'h07ff, 8'h00);
    conv(TPMR_K_IOUT, 2'h2, 16'h0832, 8'h00);
    conv(TPMR_K_IOUT, 2'h3, 16'h0fce, 8'h00);
    rd(`TPMR_CMD_IOUT_FINE, 2'h0, 16'h0190);
    rd(`TPMR_CMD_IOUT_FINE, 2'h1, 16'hfe70);
    rd(`TPMR_CMD_IOUT_FINE, 2'h2, 16'h7fff);
    rd(`TPMR_CMD_IOUT_FINE, 2'h3, 16'h8000);
    rd(`TPMR_CMD_IOUT_LOW, 2'h1, 16'h07ff);
    conv(TPMR_K_SENSE, 2'h1, 16'hfffb, 8'h00);
    rd(`TPMR_CMD_SENSE_RAW, 2'h1, 16'h0005);
    conv(TPMR_K_SENSE, 2'h0, 16'h01fa, 8'h00);
    rd(`TPMR_CMD_SENSE_RAW, 2'h0, 16'h01fa);
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Whole run needs about 170 cycles; allow 10000, about sixty times that
  initial begin
    #1000000;
    n_mismatch++;
    test_done();
  end

  initial begin
    repeat (20) @(posedge clk_i);
    rst_b <= 1'b1;
    repeat (4) @(posedge clk_i);
    t_reset();
    t_read();
    t_track();
    t_on();
    t_temp();
    t_fine();
    test_done();
  end
endmodule
`default_nettype wire
